// file: apd_chk_sva.sv
// Purpose: port checks of the auto powerdown controller
// Assumes: one clock, synchronous reset
// Notes:   run counters mirror the timers; no reset needed for 2-state
`default_nettype none
module apd_chk #(
  parameter longint IDLE_CYCLES = 200,
  parameter longint WAKE_CYCLES = 20
) (
  input wire logic                     clock_in,
  input wire logic                     srst_in,
  input wire logic                     keep_awake_in,
  input wire logic                     shutdown_req_n_in,
  input wire logic [apd_pkg::N_TX-1:0] tx_data_in,
  input wire logic [apd_pkg::N_RX-1:0] rx_data_in,
  input wire logic [apd_pkg::N_RX-1:0] rx_level_ok_in,
  input wire logic                     level_valid_out,
  input wire logic                     pump_on_out,
  input wire logic                     tx_enable_out,
  input wire logic [apd_pkg::N_TX-1:0] tx_oe_n_out,
  input wire logic                     rx_oe_n_out,
  input wire logic                     powered_down_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int quiet, vrun, irun, wrun;
  // ----
  // run counters and properties
  // ----
  always_ff @(posedge clock_in) begin
    quiet <= ($changed(tx_data_in) || $changed(rx_data_in)
              || keep_awake_in) ? 0 : quiet + 1;
    vrun <= (|rx_level_ok_in) ? vrun + 1 : 0;
    irun <= (|rx_level_ok_in) ? 0 : irun + 1;
    wrun <= (pump_on_out && !tx_enable_out) ? wrun + 1 : 0;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  property p_rx_drv; rx_oe_n_out == 1'b0; endproperty
  a_rx_drv: assert property (p_rx_drv) else $error("rx off");
  property p_down; powered_down_out |-> (&tx_oe_n_out) && !pump_on_out
    && !tx_enable_out; endproperty
  a_down: assert property (p_down) else $error("tx live");
  property p_shut; !shutdown_req_n_in [*5] |-> powered_down_out; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_keep; (keep_awake_in && shutdown_req_n_in) [*6]
    |-> !powered_down_out; endproperty
  a_keep: assert property (p_keep) else $error("keep ignored");
  property p_idle; quiet >= IDLE_CYCLES + 8 |-> powered_down_out; endproperty
  a_idle: assert property (p_idle) else $error("no timeout");
  property p_wake; $rose(tx_enable_out) |-> wrun >= WAKE_CYCLES - 1
    && wrun <= WAKE_CYCLES + 1; endproperty
  a_wake: assert property (p_wake) else $error("wake length");
  property p_lv_up; $rose(level_valid_out) |-> vrun >= 250 && vrun <= 256;
  endproperty
  a_lv_up: assert property (p_lv_up) else $error("rise time");
  property p_lv_dn; $fell(level_valid_out) |-> irun >= 7500 && irun <= 7506;
  endproperty
  a_lv_dn: assert property (p_lv_dn) else $error("fall time");
endmodule
bind serial_xcvr_auto_powerdown_ctrl apd_chk #(
  .IDLE_CYCLES(IDLE_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)
) u_chk (
  .clock_in(clock_in), .srst_in(srst_in), .keep_awake_in(keep_awake_in),
  .shutdown_req_n_in(shutdown_req_n_in), .tx_data_in(tx_data_in),
  .rx_data_in(rx_data_in), .rx_level_ok_in(rx_level_ok_in),
  .level_valid_out(level_valid_out), .pump_on_out(pump_on_out),
  .tx_enable_out(tx_enable_out), .tx_oe_n_out(tx_oe_n_out),
  .rx_oe_n_out(rx_oe_n_out), .powered_down_out(powered_down_out)
);
`default_nettype wire

// file: apd_host.sv
// Purpose: host power logic driving the force pins
// Assumes: mode 0 direct, 1 indicator on both, 2 indicator on shutdown
// Notes:   plain wiring, as a board strap would be
`default_nettype none
module apd_host (
  input  wire logic [1:0] mode_in,
  input  wire logic       level_in,
  input  wire logic       keep_in,
  input  wire logic       shut_n_in,
  output logic            keep_out,
  output logic            shut_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign keep_out = (mode_in == 2'h1) ? level_in
                  : (mode_in == 2'h2) ? 1'b0 : keep_in;
  assign shut_n_out = (mode_in == 2'h0) ? shut_n_in : level_in;
endmodule
`default_nettype wire

// file: apd_if.sv
// Purpose: carries synchronised line samples between modules
// Assumes: single clock
// Notes:   none
`default_nettype none
interface apd_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic [apd_pkg::N_RX-1:0] rx_valid;
  logic                     any_edge;
  modport src (output rx_valid, output any_edge);
  modport dst (input rx_valid, input any_edge);
endinterface
`default_nettype wire

// file: apd_level.sv
// Purpose: receiver level-valid indicator with asymmetric persistence
// Assumes: valid flags already synchronised
// Notes:   indicator feeds power logic only via the host force pins in every mode except 0
`default_nettype none
module apd_level (
  input  wire logic clock_in,
  input  wire logic srst_in,
  apd_if.dst        lines,
  output logic      level_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [apd_pkg::CNT_W-1:0] cnt;
  wire any_ok    = |lines.rx_valid;
  // counting only while the lines disagree with the indicator means a
  // single bounce restarts the whole persistence span
  wire differs   = any_ok != level_valid_out;
  // [RULE2] rise after 1us
  wire rise_done = any_ok &&
                   apd_pkg::count_reached(cnt, apd_pkg::VALID_CYC);
  // [RULE1] fall after 30us
  wire fall_done = !any_ok &&
                   apd_pkg::count_reached(cnt, apd_pkg::INVALID_CYC);

  // ---------------------------------------------------------------
  // persistence counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cnt             <= '0;
      level_valid_out <= 1'h0;
    end else if (!differs) begin
      cnt <= '0;
    end else if (rise_done) begin
      cnt             <= '0;
      level_valid_out <= 1'h1;
    end else if (fall_done) begin
      cnt             <= '0;
      level_valid_out <= 1'h0;
    end else begin
      cnt <= cnt + 1'h1;
    end
  end
endmodule
`default_nettype wire

// file: apd_pkg.sv
// Purpose: shared constants and types for the auto powerdown controller
// Assumes: 250 MHz clock_in
// Notes:   counts derive from times and the clock rate
`default_nettype none
package apd_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // widths and clock
  // ---------------------------------------------------------------
  localparam int N_TX = 3;
  localparam int N_RX = 3;
  localparam longint CLK_HZ = 250_000_000;

  // ---------------------------------------------------------------
  // times in their own units
  // ---------------------------------------------------------------
  localparam longint INVALID_NS = 30_000;
  localparam longint VALID_NS = 1_000;
  localparam longint IDLE_S = 30;
  localparam longint WAKE_NS = 100_000;

  // ---------------------------------------------------------------
  // cycle counts: least times round up
  // ---------------------------------------------------------------
  localparam longint INVALID_CYC =
    (INVALID_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam longint VALID_CYC =
    (VALID_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam longint IDLE_CYC = IDLE_S * CLK_HZ;
  localparam longint WAKE_CYC =
    (WAKE_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam int CNT_W = 34;

  // counters start at zero, so limit - 1 is the last cycle of a span
  function automatic logic count_reached(
    input logic [CNT_W-1:0] cnt,
    input longint           limit
  );
    return cnt >= CNT_W'(limit - 1);
  endfunction

  typedef enum logic [1:0] {ACTIVE, POWERED_DOWN, WAKING} pwr_state_t;
endpackage
`default_nettype wire

// file: apd_sync.sv
// Purpose: two-flop synchronisers and edge detection on monitored lines
// Assumes: lines are asynchronous to clock_in
// Notes:   edges are taken only from second-stage samples
`default_nettype none
module apd_sync (
  input  wire logic                     clock_in,
  input  wire logic                     srst_in,
  input  wire logic [apd_pkg::N_TX-1:0] tx_data_in,
  input  wire logic [apd_pkg::N_RX-1:0] rx_data_in,
  input  wire logic [apd_pkg::N_RX-1:0] rx_level_ok_in,
  apd_if.src                            lines
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int W = apd_pkg::N_TX + 2 * apd_pkg::N_RX;
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;
  logic         primed;
  wire  [W-1:0] raw = {rx_level_ok_in, rx_data_in, tx_data_in};
  localparam int DW = apd_pkg::N_TX + apd_pkg::N_RX;

  always_ff @(posedge clock_in) begin
    meta   <= raw;
    stable <= meta;
    prev   <= stable;
    if (srst_in) begin
      primed <= 1'h0;
    end else begin
      primed <= 1'h1;
    end
  end

  // [RULE16] sample compare edges
  assign lines.any_edge = primed && ((stable[DW-1:0] ^ prev[DW-1:0]) != '0);
  assign lines.rx_valid = stable[W-1:DW];
endmodule
`default_nettype wire

// file: serial_xcvr_auto_powerdown_ctrl.sv
// Purpose: power control of a multi-channel serial line transceiver
// Assumes: 250 MHz clock_in, synchronous active-high reset
// Notes:   analog matters are outside this block
//
// Notes on behaviour
// [RULE1] The indicator falls once all receivers were invalid for 30 us.
// [RULE2] The indicator rises 1 us after any receiver level becomes valid.
// [RULE3] The indicator works in every power mode.
// [RULE4] The indicator never changes the power state by itself.
// [RULE5] 30 s without line edges powers down pump and drivers if auto on.
// [RULE6] An edge in auto powerdown wakes the part and restarts the timer.
// [RULE7] Auto powerdown runs only with keep-awake low and shutdown high.
// [RULE8] Keep-awake disables auto powerdown; shutdown low always wins.
// [RULE9] In powerdown the timer stays expired until keep-awake or an edge.
// [RULE10] Recovery from powerdown to transmission takes about 100 us.
// [RULE11] The system may tie the indicator to both force inputs.
// [RULE12] The system may tie the indicator to shutdown with keep-awake low.
// [RULE13] Transmitter outputs are high impedance in powerdown.
// [RULE14] Receiver outputs stay driven in every mode.
// [RULE15] After keep-awake falls the part stays up for 30 s.
// [RULE16] Inputs are synchronised, edges found by compare, counters timed.
// [RULE17] Receiver validity arrives as a digital flag per input.
`default_nettype none
module serial_xcvr_auto_powerdown_ctrl #(
  parameter longint IDLE_CYCLES = apd_pkg::IDLE_CYC,
  parameter longint WAKE_CYCLES = apd_pkg::WAKE_CYC
) (
  input  wire logic                     clock_in,
  input  wire logic                     srst_in,
  input  wire logic                     keep_awake_in,
  input  wire logic                     shutdown_req_n_in,
  input  wire logic [apd_pkg::N_TX-1:0] tx_data_in,
  input  wire logic [apd_pkg::N_RX-1:0] rx_data_in,
  input  wire logic [apd_pkg::N_RX-1:0] rx_level_ok_in,
  output logic                          level_valid_out,
  output logic                          pump_on_out,
  output logic                          tx_enable_out,
  output logic [apd_pkg::N_TX-1:0]      tx_oe_n_out,
  output logic                          rx_oe_n_out,
  output logic                          powered_down_out
);
  timeunit 1ns;
  timeprecision 1ps;

  apd_if lines ();

  // ---------------------------------------------------------------
  // registers and their next values
  // ---------------------------------------------------------------
  logic                      keep_meta;
  logic                      keep;
  logic                      keep_prev;
  logic                      shdn_meta;
  logic                      shdn_n;
  logic [apd_pkg::CNT_W-1:0] idle_cnt;
  logic [apd_pkg::CNT_W-1:0] next_idle_cnt;
  logic [apd_pkg::CNT_W-1:0] wake_cnt;
  logic [apd_pkg::CNT_W-1:0] next_wake_cnt;
  logic                      expired;
  logic                      next_expired;
  apd_pkg::pwr_state_t       state;
  apd_pkg::pwr_state_t       next_state;

  // ---------------------------------------------------------------
  // line sampling and indicator
  // ---------------------------------------------------------------
  // [RULE17] flags per receiver
  apd_sync u_sync (
    .clock_in       (clock_in),
    .srst_in        (srst_in),
    .tx_data_in     (tx_data_in),
    .rx_data_in     (rx_data_in),
    .rx_level_ok_in (rx_level_ok_in),
    .lines          (lines)
  );

  // [RULE3] indicator always runs
  apd_level u_level (
    .clock_in        (clock_in),
    .srst_in         (srst_in),
    .lines           (lines),
    .level_valid_out (level_valid_out)
  );

  // ---------------------------------------------------------------
  // force input synchronisers
  // ---------------------------------------------------------------
  // keep_prev reads the second stage only, so a metastable first
  // stage can never fake a rising edge of keep-awake
  always_ff @(posedge clock_in) begin
    keep_meta <= keep_awake_in;
    keep      <= keep_meta;
    keep_prev <= keep;
  end

  always_ff @(posedge clock_in) begin
    shdn_meta <= shutdown_req_n_in;
    shdn_n    <= shdn_meta;
  end

  // ---------------------------------------------------------------
  // state decode
  // ---------------------------------------------------------------
  wire in_active = state == apd_pkg::ACTIVE;
  wire in_down   = state == apd_pkg::POWERED_DOWN;
  wire in_waking = state == apd_pkg::WAKING;

  // ---------------------------------------------------------------
  // force and wake decode
  // ---------------------------------------------------------------
  wire keep_rise = keep && !keep_prev;
  // [RULE7] auto mode condition
  wire auto_en   = !keep && shdn_n;
  wire shut_now  = !shdn_n;
  // [RULE4] indicator not used here
  wire wake_ev   = lines.any_edge || keep_rise;
  // keep-awake as a level also wakes, so a strap that is already high
  // when shutdown is released brings the part up without an edge
  wire wake_ok   = shdn_n && (wake_ev || keep);

  // ---------------------------------------------------------------
  // inactivity timer
  // ---------------------------------------------------------------
  // [RULE15] keep-awake restarts timer
  wire timer_clear = keep || lines.any_edge;
  // [RULE9] hold expired in powerdown
  wire timer_hold  = shut_now || in_down;
  wire idle_done   = apd_pkg::count_reached(idle_cnt, IDLE_CYCLES);
  // the counter parks once expired so it can never wrap
  wire timer_run   = !expired && !idle_done;

  // an edge restarts the span even in the cycle that would time out
  assign next_idle_cnt = (timer_clear || timer_hold) ? '0
                       : timer_run                   ? idle_cnt + 1'h1
                       :                               idle_cnt;
  assign next_expired  = timer_clear                 ? 1'h0
                       : (timer_hold || idle_done)   ? 1'h1
                       :                               expired;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      idle_cnt <= '0;
      expired  <= 1'h0;
    end else begin
      idle_cnt <= next_idle_cnt;
      expired  <= next_expired;
    end
  end

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  // [RULE5] idle timeout
  wire idle_timeout = auto_en && expired && !wake_ev;
  // [RULE10] pump settle
  wire wake_done    = apd_pkg::count_reached(wake_cnt, WAKE_CYCLES);

  always_comb begin
    next_state = state;
    case (state)
      apd_pkg::ACTIVE: begin
        // [RULE8] shutdown overrides
        if (shut_now) begin
          next_state = apd_pkg::POWERED_DOWN;
        // [RULE5] idle timeout
        end else if (idle_timeout) begin
          next_state = apd_pkg::POWERED_DOWN;
        end
      end
      apd_pkg::POWERED_DOWN: begin
        // [RULE6] wake on edge
        if (wake_ok) begin
          next_state = apd_pkg::WAKING;
        end
      end
      apd_pkg::WAKING: begin
        // [RULE8] shutdown cuts a wake short
        if (shut_now) begin
          next_state = apd_pkg::POWERED_DOWN;
        end else if (wake_done) begin
          next_state = apd_pkg::ACTIVE;
        end
      end
      default: begin
        next_state = apd_pkg::POWERED_DOWN;
      end
    endcase
  end

  // the settle counter only runs in wake, so every wake is full length
  assign next_wake_cnt = in_waking ? wake_cnt + 1'h1 : '0;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state    <= apd_pkg::POWERED_DOWN;
      wake_cnt <= '0;
    end else begin
      state    <= next_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // pump runs during wake so the drivers see full rails when enabled
  assign pump_on_out      = !in_down;
  assign tx_enable_out    = in_active;
  // [RULE13] drivers high impedance
  assign tx_oe_n_out      = {apd_pkg::N_TX{!in_active}};
  // [RULE14] receivers always driven
  assign rx_oe_n_out      = 1'h0;
  assign powered_down_out = in_down;
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench of the powerdown controller
// Assumes: short idle and wake counts so the run stays brief
// Notes:   checks fall well clear of sync jitter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_in, srst_in, keep, shut_n, ka, sn;
  logic       lv, pump, tx_en, rx_oe_n, down;
  logic [1:0] mode;
  logic [2:0] tx_d, rx_d, rx_ok, tx_oe_n;
  logic [5:0] st;
  int         n_mismatch, check_count;
  assign st = {down, pump, tx_en, tx_oe_n};
  apd_host host (.mode_in(mode), .level_in(lv), .keep_in(keep),
    .shut_n_in(shut_n), .keep_out(ka), .shut_n_out(sn));
  serial_xcvr_auto_powerdown_ctrl #(.IDLE_CYCLES(200), .WAKE_CYCLES(20)) dut (
    .clock_in(clock_in), .srst_in(srst_in), .keep_awake_in(ka),
    .shutdown_req_n_in(sn), .tx_data_in(tx_d), .rx_data_in(rx_d),
    .rx_level_ok_in(rx_ok), .level_valid_out(lv), .pump_on_out(pump),
    .tx_enable_out(tx_en), .tx_oe_n_out(tx_oe_n), .rx_oe_n_out(rx_oe_n),
    .powered_down_out(down));
  // ----
  // helpers
  // ----
  function automatic logic [5:0] pw(input int s);
    return (s == 0) ? 6'h27 : (s == 1) ? 6'h17 : 6'h18;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic chk(input string nm, input logic [5:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wake();
    int b;
    b = $urandom % 6;
    if (b < 3) tx_d[b] = ~tx_d[b];
    else rx_d[b-3] = ~rx_d[b-3];
    tick(6);
    chk("waking", st, pw(1));
    tick(24);
    chk("active", st, pw(2));
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    #200us;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    srst_in = 1'b1;
    {keep, shut_n, mode, tx_d, rx_d, rx_ok} = {1'b0, 1'b1, 11'h000};
    void'($urandom(32'h8EBD));
    tick(6);
    srst_in = 1'b0;
    chk("reset", st, pw(0));
    chk("rx_oe", {5'h00, rx_oe_n}, 6'h00);
    for (int i = 0; i < 6; i++) begin
      wake();
      tick(160);
      chk("idle", st, pw(2));
      tick(20);
      chk("sleep", st, pw(0));
    end
    tick(300);
    chk("held", st, pw(0));
    keep = 1'b1;
    tick(30);
    chk("keep", st, pw(2));
    tick(400);
    chk("no_auto", st, pw(2));
    keep = 1'b0;
    tick(190);
    chk("grace", st, pw(2));
    tick(20);
    chk("grace_end", st, pw(0));
    keep = 1'b1;
    tick(30);
    shut_n = 1'b0;
    tick(6);
    chk("shut", st, pw(0));
    shut_n = 1'b1;
    tick(30);
    chk("unshut", st, pw(2));
    {keep, shut_n} = 2'h0;
    tick(6);
    tx_d[0] = ~tx_d[0];
    tick(30);
    chk("refused", st, pw(0));
    rx_ok = 3'($urandom % 7 + 1);
    tick(248);
    chk("lv_early", {5'h00, lv}, 6'h00);
    tick(8);
    chk("lv_rise", {5'h00, lv}, 6'h01);
    shut_n = 1'h1;
    rx_ok = 3'h4;
    tick(8000);
    chk("lv_one", {5'h00, lv}, 6'h01);
    chk("lv_no_pwr", st, pw(0));
    rx_ok = 3'h0;
    tick(7495);
    chk("lv_hold", {5'h00, lv}, 6'h01);
    tick(15);
    chk("lv_fall", {5'h00, lv}, 6'h00);
    mode = 2'h2;
    rx_ok = 3'h2;
    tick(300);
    chk("cable", st, pw(0));
    wake();
    mode = 2'h1;
    rx_ok = 3'h0;
    tick(7520);
    chk("strap_dn", st, pw(0));
    rx_ok = 3'h1;
    tick(290);
    chk("strap_up", st, pw(2));
    tally_and_finish();
  end
endmodule
`default_nettype wire
